// ---- core/hab_top.v ----
// HDLC auto-mode link engine with bus access, clock generation and AHB-Lite registers
// Behaviour
// - Auto mode handles S and I frames itself, window one, checking sequence counters.
// - Unnumbered frames always go to the receive queue for the host.
// - Receiver reset command restarts the link procedure at any time.
// - S frames raise events on remote busy change or protocol error, and ready or repeat events when they end an outstanding I frame.
// - Out-of-sequence I frames are dropped silently and acknowledged by S response.
// - Local not-ready refuses I frames silently and answers with RNR.
// - I frames need internal timer; after sending, timer runs, queue blocked.
// - On t1 expiry send S command with poll, retry up to n1 times.
// - On acknowledge or poll end unblock queue and flag ready, repeat or timeout.
// - After RNR poll every t1 until ready, timeout event after n1 misses.
// - Transparent frames in any mode release queue at once with ready event.
// - Request-to-send lags data one bit, marking bits sent without collision.
// - Bus idle after eight ones; busy from own first opening zero.
// - Output idles at continuous ones after frames or without access.
// - Bit mismatch against bus aborts at once, sends ones, retries soon unless past the 35th frame byte.
// - After success need ten ones before next frame, then back to eight.
// - Reference clock is oscillator divided by 1, 2, 4, 6 up to 2048.
// - DPLL data clock is reference divided by 16, phased to received data.
// - Bus mode works with any clock mode, including external strobes.
// - Collision after 35th frame byte ends frame with repeat event.
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
`include "hab_consts.vh"
module hab_top (
	// Clock and reset
	input wire i_mclk,
	input wire i_srst,
	// AHB-Lite slave
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	output reg [31:0] o_hrdata,
	output reg o_hreadyout,
	output reg o_hresp,
	// Decoded received frame
	input wire i_rx_valid,
	input wire [1:0] i_rx_kind,
	input wire [1:0] i_rx_stype,
	input wire [2:0] i_rx_ns,
	input wire [2:0] i_rx_nr,
	input wire i_rx_pf,
	input wire i_rx_cmd,
	input wire i_rx_info,
	output reg o_rxq_push,
	output reg o_rxq_drop,
	output reg o_rx_reset,
	// Frame build requests
	output reg o_s_req,
	output reg [1:0] o_s_type,
	output reg [2:0] o_s_nr,
	output reg o_s_pf,
	output reg o_s_cmd,
	output reg o_i_req,
	output reg [2:0] o_i_ns,
	output reg [2:0] o_i_nr,
	output reg o_t_req,
	output reg o_transmit_queue_blocked,
	input wire i_tx_done,
	// Serial bit source
	input wire i_txb_valid,
	input wire i_txb_data,
	input wire i_txb_last,
	output wire o_txb_take,
	output wire o_txb_restart,
	output wire o_txb_flush,
	output wire o_txb_done,
	// Line and clocks
	input wire i_rxd,
	input wire i_ext_strobe,
	input wire i_bus_feedback_in,
	output wire o_serial_data_out,
	output wire o_request_to_send_out,
	output wire o_bus_busy,
	output wire o_ref_clk_en,
	output wire o_bit_clk_en
);

localparam ST_IDLE = 2'h0;
localparam ST_WACK = 2'h1;
localparam ST_POLL = 2'h2;
localparam ST_RBSY = 2'h3;

function [2:0] inc3;
	input [2:0] v;
	begin
		inc3 = v + 3'h1;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Register bus

reg wr_reg;
reg rd_reg;
reg [7:0] adr_reg;
reg [`HAB_C_W-1:0] ctrl_reg;
reg [27:0] timing_control_reg;
reg [10:0] baud_divider_reg;
reg [`HAB_E_W-1:0] evt_reg;
reg [`HAB_E_W-1:0] evp_reg;
reg [1:0] state_reg;
reg [2:0] vs_reg;
reg [2:0] vr_reg;
reg rbusy_reg;
reg out_reg;
reg pend_i_reg;
reg pend_t_reg;
reg [23:0] tmr_reg;
reg [3:0] try_reg;
reg [31:0] rdata;
wire acc = i_hsel & i_htrans[1] & i_hready;
wire cmd_w = wr_reg & (adr_reg == `HAB_A_CMD);
wire cmd_rhr = cmd_w & i_hwdata[`HAB_M_RHR];
wire cmd_xi = cmd_w & i_hwdata[`HAB_M_XI];
wire cmd_xt = cmd_w & i_hwdata[`HAB_M_XT];
wire [`HAB_E_W-1:0] evt_clr = (wr_reg & (adr_reg == `HAB_A_EVT)) ?
	i_hwdata[`HAB_E_W-1:0] : {`HAB_E_W{1'b0}};
wire bus_xmr;

always @*
begin
	rdata = 32'h0000_0000;
	case (adr_reg)
	`HAB_A_CTRL: rdata[`HAB_C_W-1:0] = ctrl_reg;
	`HAB_A_STAT: rdata[12:0] = {o_transmit_queue_blocked, pend_i_reg, pend_t_reg, rbusy_reg,
		out_reg, state_reg, vr_reg, vs_reg};
	`HAB_A_EVT: rdata[`HAB_E_W-1:0] = evt_reg;
	`HAB_A_TIM: rdata[27:0] = timing_control_reg;
	`HAB_A_BAUD: rdata[10:0] = baud_divider_reg;
	default: rdata = 32'h0000_0000;
	endcase
end

// Reads take one wait state so a preceding write is always visible
always @(posedge i_mclk)
begin
	if (i_srst)
	begin
		wr_reg <= 1'b0;
		rd_reg <= 1'b0;
		adr_reg <= 8'h00;
		o_hrdata <= 32'h0000_0000;
		o_hreadyout <= 1'b1;
		o_hresp <= 1'b0;
		ctrl_reg <= `HAB_CTRL_RST;
		timing_control_reg <= `HAB_TIM_RST;
		baud_divider_reg <= `HAB_BAUD_RST;
		evt_reg <= {`HAB_E_W{1'b0}};
	end
	else
	begin
		o_hresp <= 1'b0;
		wr_reg <= acc & i_hwrite;
		rd_reg <= acc & ~i_hwrite;
		if (acc)
			adr_reg <= i_haddr[7:0];
		if (rd_reg)
		begin
			o_hrdata <= rdata;
			o_hreadyout <= 1'b1;
		end
		else if (acc & ~i_hwrite)
			o_hreadyout <= 1'b0;
		if (wr_reg)
		begin
			case (adr_reg)
			`HAB_A_CTRL: ctrl_reg <= i_hwdata[`HAB_C_W-1:0];
			`HAB_A_TIM: timing_control_reg <= i_hwdata[27:0];
			`HAB_A_BAUD: baud_divider_reg <= i_hwdata[10:0];
			default: ctrl_reg <= ctrl_reg;
			endcase
		end
		// A new event wins over a clear in the same cycle
		evt_reg <= (evt_reg & ~evt_clr) | evp_reg;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Link procedure

wire auto = ctrl_reg[`HAB_C_AUTO];
wire lrnr = ctrl_reg[`HAB_C_LRNR];
wire [23:0] t1 = timing_control_reg[`HAB_T_T1_HI:0];
wire [3:0] n1 = timing_control_reg[`HAB_T_N1_HI:`HAB_T_N1_LO];
wire rx_s = i_rx_valid & auto & (i_rx_kind == `HAB_K_S);
wire rx_i = i_rx_valid & auto & (i_rx_kind == `HAB_K_I);
wire rx_q = i_rx_valid & (~auto | (i_rx_kind == `HAB_K_U));
wire nr_ack = out_reg & (i_rx_nr == inc3(vs_reg));
wire nr_bad = (i_rx_nr != vs_reg) & ~nr_ack;
wire [1:0] my_type = lrnr ? `HAB_S_RNR : `HAB_S_RR;
wire s_busy = (i_rx_stype == `HAB_S_RNR);

always @(posedge i_mclk)
begin
	if (i_srst)
	begin
		evp_reg <= {`HAB_E_W{1'b0}};
		state_reg <= ST_IDLE;
		vs_reg <= 3'h0;
		vr_reg <= 3'h0;
		rbusy_reg <= 1'b0;
		out_reg <= 1'b0;
		pend_i_reg <= 1'b0;
		pend_t_reg <= 1'b0;
		tmr_reg <= 24'h00_0000;
		try_reg <= 4'h0;
		o_rxq_push <= 1'b0;
		o_rxq_drop <= 1'b0;
		o_rx_reset <= 1'b0;
		o_s_req <= 1'b0;
		o_s_type <= `HAB_S_RR;
		o_s_nr <= 3'h0;
		o_s_pf <= 1'b0;
		o_s_cmd <= 1'b0;
		o_i_req <= 1'b0;
		o_i_ns <= 3'h0;
		o_i_nr <= 3'h0;
		o_t_req <= 1'b0;
		o_transmit_queue_blocked <= 1'b0;
	end
	else
	begin
		evp_reg <= {`HAB_E_W{1'b0}};
		o_rxq_push <= 1'b0;
		o_rxq_drop <= 1'b0;
		o_s_req <= 1'b0;
		o_i_req <= 1'b0;
		o_t_req <= 1'b0;
		o_rx_reset <= cmd_rhr;
		o_s_nr <= vr_reg;
		if (cmd_rhr)
		begin
			state_reg <= ST_IDLE;
			vs_reg <= 3'h0;
			vr_reg <= 3'h0;
			rbusy_reg <= 1'b0;
			out_reg <= 1'b0;
			pend_i_reg <= 1'b0;
			o_transmit_queue_blocked <= pend_t_reg;
		end
		else
		begin
			// Host transmit commands
			if (cmd_xi & auto & ctrl_reg[`HAB_C_TINT] & ~o_transmit_queue_blocked &
				(state_reg == ST_IDLE))
			begin
				o_i_req <= 1'b1;
				o_i_ns <= vs_reg;
				o_i_nr <= vr_reg;
				pend_i_reg <= 1'b1;
				o_transmit_queue_blocked <= 1'b1;
			end
			else if (cmd_xt & ~o_transmit_queue_blocked)
			begin
				o_t_req <= 1'b1;
				pend_t_reg <= 1'b1;
				o_transmit_queue_blocked <= 1'b1;
			end
			if (i_tx_done & pend_t_reg)
			begin
				pend_t_reg <= 1'b0;
				o_transmit_queue_blocked <= 1'b0;
				evp_reg[`HAB_E_XPR] <= 1'b1;
			end
			else if (i_tx_done & pend_i_reg)
			begin
				pend_i_reg <= 1'b0;
				out_reg <= 1'b1;
				state_reg <= ST_WACK;
				tmr_reg <= t1;
				try_reg <= 4'h0;
			end
			if (bus_xmr)
			begin
				pend_t_reg <= 1'b0;
				pend_i_reg <= 1'b0;
				o_transmit_queue_blocked <= 1'b0;
				evp_reg[`HAB_E_XMR] <= 1'b1;
			end
			// Timer and poll cycle
			if (state_reg != ST_IDLE)
			begin
				if (tmr_reg != 24'h00_0000)
					tmr_reg <= tmr_reg - 24'h00_0001;
				else if (try_reg == n1)
				begin
					state_reg <= ST_IDLE;
					out_reg <= 1'b0;
					o_transmit_queue_blocked <= 1'b0;
					evp_reg[`HAB_E_TIN] <= 1'b1;
				end
				else
				begin
					try_reg <= try_reg + 4'h1;
					tmr_reg <= t1;
					if (state_reg == ST_WACK)
						state_reg <= ST_POLL;
					o_s_req <= 1'b1;
					o_s_type <= my_type;
					o_s_pf <= 1'b1;
					o_s_cmd <= 1'b1;
				end
			end
			// Received frames
			if (rx_q)
				o_rxq_push <= 1'b1;
			if ((rx_s | rx_i) & (nr_bad | (rx_s & i_rx_info)))
			begin
				evp_reg[`HAB_E_PCE] <= 1'b1;
				o_rxq_drop <= rx_i;
			end
			else if (rx_s | rx_i)
			begin
				if (nr_ack)
				begin
					vs_reg <= inc3(vs_reg);
					out_reg <= 1'b0;
					state_reg <= ST_IDLE;
					o_transmit_queue_blocked <= 1'b0;
					evp_reg[`HAB_E_XPR] <= 1'b1;
				end
				else if (out_reg & rx_s & ((i_rx_stype == `HAB_S_REJ) |
					((state_reg == ST_POLL) & ~i_rx_cmd & i_rx_pf)))
				begin
					out_reg <= 1'b0;
					state_reg <= ST_IDLE;
					o_transmit_queue_blocked <= 1'b0;
					evp_reg[`HAB_E_XMR] <= 1'b1;
				end
				if (rx_s)
				begin
					if (s_busy != rbusy_reg)
						evp_reg[`HAB_E_RSC] <= 1'b1;
					if (i_rx_stype != `HAB_S_REJ)
						rbusy_reg <= s_busy;
					if (s_busy)
					begin
						state_reg <= ST_RBSY;
						tmr_reg <= t1;
						try_reg <= 4'h0;
					end
					else if (state_reg == ST_RBSY)
						state_reg <= (out_reg & ~nr_ack) ? ST_WACK : ST_IDLE;
					if (i_rx_cmd & i_rx_pf)
					begin
						o_s_req <= 1'b1;
						o_s_type <= my_type;
						o_s_pf <= 1'b1;
						o_s_cmd <= 1'b0;
					end
				end
				else
				begin
					o_s_req <= 1'b1;
					o_s_cmd <= 1'b0;
					o_s_pf <= i_rx_pf & i_rx_cmd;
					if (lrnr)
					begin
						o_rxq_drop <= 1'b1;
						o_s_type <= `HAB_S_RNR;
					end
					else if (i_rx_ns != vr_reg)
					begin
						o_rxq_drop <= 1'b1;
						o_s_type <= `HAB_S_RR;
					end
					else
					begin
						vr_reg <= inc3(vr_reg);
						o_s_nr <= inc3(vr_reg);
						o_rxq_push <= 1'b1;
						o_s_type <= `HAB_S_RR;
					end
				end
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Clock generation and bus access

wire bit_en;

hab_clkgen u_clk (
	.i_mclk(i_mclk),
	.i_srst(i_srst),
	.i_ratio_k(baud_divider_reg),
	.i_dpll(ctrl_reg[`HAB_C_DPLL]),
	.i_ext(ctrl_reg[`HAB_C_EXT]),
	.i_ext_strobe(i_ext_strobe),
	.i_rxd(i_rxd),
	.o_ref_en(o_ref_clk_en),
	.o_bit_en(bit_en)
);

assign o_bit_clk_en = bit_en;
assign o_txb_flush = bus_xmr;

hab_busacc u_bus (
	.i_mclk(i_mclk),
	.i_srst(i_srst),
	.i_bit_en(bit_en),
	.i_bus_mode(ctrl_reg[`HAB_C_BUS]),
	.i_txb_valid(i_txb_valid),
	.i_txb_data(i_txb_data),
	.i_txb_last(i_txb_last),
	.o_take(o_txb_take),
	.o_restart(o_txb_restart),
	.o_flush(bus_xmr),
	.o_done(o_txb_done),
	.i_bus_fb(i_bus_feedback_in),
	.o_txd(o_serial_data_out),
	.o_rts(o_request_to_send_out),
	.o_busy(o_bus_busy)
);

endmodule

// ---- core/hab_consts.vh ----
// Shared constants for the HDLC auto-mode and bus access block
`ifndef HAB_CONSTS_VH
`define HAB_CONSTS_VH
// Register byte offsets
`define HAB_A_CTRL 8'h00
`define HAB_A_CMD 8'h04
`define HAB_A_STAT 8'h08
`define HAB_A_EVT 8'h0c
`define HAB_A_TIM 8'h10
`define HAB_A_BAUD 8'h14
// Control register bits
`define HAB_C_AUTO 0
`define HAB_C_TINT 1
`define HAB_C_LRNR 2
`define HAB_C_BUS 3
`define HAB_C_DPLL 4
`define HAB_C_EXT 5
`define HAB_C_W 6
// Command register bits
`define HAB_M_RHR 0
`define HAB_M_XI 1
`define HAB_M_XT 2
// Event register bits
`define HAB_E_XPR 0
`define HAB_E_XMR 1
`define HAB_E_TIN 2
`define HAB_E_RSC 3
`define HAB_E_PCE 4
`define HAB_E_W 5
// Timing control register fields
`define HAB_T_T1_HI 23
`define HAB_T_N1_LO 24
`define HAB_T_N1_HI 27
// Frame kinds and supervisory types
`define HAB_K_I 2'h0
`define HAB_K_S 2'h1
`define HAB_K_U 2'h2
`define HAB_S_RR 2'h0
`define HAB_S_RNR 2'h1
`define HAB_S_REJ 2'h2
// Reset values
`define HAB_CTRL_RST 6'h00
`define HAB_TIM_RST 28'h300_ffff
`define HAB_BAUD_RST 11'h000
// Bus access and clock generation counts
`define HAB_IDLE_NORM 4'h8
`define HAB_IDLE_LOW 4'ha
`define HAB_ONES_MAX 4'hf
`define HAB_COLL_LIM 6'h23
`define HAB_DPLL_LAST 4'hf
`define HAB_DPLL_MID 4'h8
`define HAB_BAUD_MAXK 11'h400
`endif

// ---- core/hab_clkgen.v ----
// Baud rate divider and DPLL data clock enable generator
`timescale 1ns/10ps
`include "hab_consts.vh"
module hab_clkgen (
	// Clock and reset
	input wire i_mclk,
	input wire i_srst,
	// Configuration
	input wire [10:0] i_ratio_k,
	input wire i_dpll,
	input wire i_ext,
	input wire i_ext_strobe,
	// Received line data for phase alignment
	input wire i_rxd,
	// Clock enables
	output reg o_ref_en,
	output reg o_bit_en
);

reg [11:0] div_reg;
reg [3:0] ph_reg;
reg rxd_reg;
wire [10:0] k_sat = (i_ratio_k > `HAB_BAUD_MAXK) ? `HAB_BAUD_MAXK : i_ratio_k;
// Ratio 1 for k of zero, otherwise 2k, with k held at 1024 at most
wire [11:0] lim = (k_sat == 11'h000) ? 12'h000 : ({k_sat, 1'b0} - 12'h001);
wire ref_tick = (div_reg >= lim);
wire edge_seen = i_rxd ^ rxd_reg;

always @(posedge i_mclk)
begin
	if (i_srst)
	begin
		div_reg <= 12'h000;
		ph_reg <= 4'h0;
		rxd_reg <= 1'b1;
		o_ref_en <= 1'b0;
		o_bit_en <= 1'b0;
	end
	else
	begin
		rxd_reg <= i_rxd;
		div_reg <= ref_tick ? 12'h000 : div_reg + 12'h001;
		o_ref_en <= ref_tick;
		// Realign mid-bit on each data edge; jitter filtering is left to the receiver
		if (i_dpll & edge_seen)
			ph_reg <= `HAB_DPLL_MID;
		else if (ref_tick)
			ph_reg <= ph_reg + 4'h1;
		if (i_ext)
			o_bit_en <= i_ext_strobe;
		else if (i_dpll)
			o_bit_en <= ref_tick & (ph_reg == `HAB_DPLL_LAST) & ~edge_seen;
		else
			o_bit_en <= ref_tick;
	end
end

endmodule

// ---- core/hab_busacc.v ----
// Serial bus access engine with collision detection and rotating priority
`timescale 1ns/10ps
`include "hab_consts.vh"
module hab_busacc (
	// Clock and reset
	input wire i_mclk,
	input wire i_srst,
	input wire i_bit_en,
	input wire i_bus_mode,
	// Bit source from the frame transmitter
	input wire i_txb_valid,
	input wire i_txb_data,
	input wire i_txb_last,
	output reg o_take,
	output reg o_restart,
	output reg o_flush,
	output reg o_done,
	// Line
	input wire i_bus_fb,
	output reg o_txd,
	output reg o_rts,
	output reg o_busy
);

reg ones_reg_v;
reg [3:0] ones_reg;
reg low_reg;
reg tx_reg;
reg sent_reg;
reg chk_reg;
reg last_reg;
reg [2:0] bit_reg;
reg [5:0] byte_reg;
wire [3:0] need = low_reg ? `HAB_IDLE_LOW : `HAB_IDLE_NORM;
wire idle = (ones_reg >= need);
// Feedback relies on a wired-OR bus with zero dominant and a shared clock
wire coll = i_bus_mode & chk_reg & (i_bus_fb != sent_reg);

always @(posedge i_mclk)
begin
	if (i_srst)
	begin
		ones_reg <= 4'h0;
		low_reg <= 1'b0;
		tx_reg <= 1'b0;
		sent_reg <= 1'b1;
		chk_reg <= 1'b0;
		last_reg <= 1'b0;
		bit_reg <= 3'h0;
		byte_reg <= 6'h00;
		o_take <= 1'b0;
		o_restart <= 1'b0;
		o_flush <= 1'b0;
		o_done <= 1'b0;
		o_txd <= 1'b1;
		o_rts <= 1'b0;
		o_busy <= 1'b0;
	end
	else
	begin
		o_take <= 1'b0;
		o_restart <= 1'b0;
		o_flush <= 1'b0;
		o_done <= 1'b0;
		if (i_bit_en)
		begin
			// Count consecutive ones seen on the bus
			if (!i_bus_fb)
				ones_reg <= 4'h0;
			else if (ones_reg != `HAB_ONES_MAX)
				ones_reg <= ones_reg + 4'h1;
			// Strobe marks each bit that went out without collision, one period late
			o_rts <= tx_reg & chk_reg & ~coll;
			if (tx_reg)
			begin
				if (coll)
				begin
					tx_reg <= 1'b0;
					chk_reg <= 1'b0;
					o_txd <= 1'b1;
					o_busy <= 1'b0;
					// Address fields differ, so early collisions are the normal case
					if (byte_reg > `HAB_COLL_LIM)
						o_flush <= 1'b1;
					else
						o_restart <= 1'b1;
				end
				else if (chk_reg & last_reg)
				begin
					tx_reg <= 1'b0;
					chk_reg <= 1'b0;
					o_txd <= 1'b1;
					o_busy <= 1'b0;
					o_done <= 1'b1;
					low_reg <= i_bus_mode;
				end
				else if (i_txb_valid)
				begin
					o_txd <= i_txb_data;
					sent_reg <= i_txb_data;
					chk_reg <= 1'b1;
					last_reg <= i_txb_last;
					o_take <= 1'b1;
					o_busy <= o_busy | ~i_txb_data;
					bit_reg <= bit_reg + 3'h1;
					if ((bit_reg == 3'h7) && (byte_reg != 6'h3f))
						byte_reg <= byte_reg + 6'h01;
				end
				else
				begin
					chk_reg <= 1'b0;
					o_txd <= 1'b1;
				end
			end
			else if (i_txb_valid & (~i_bus_mode | idle))
			begin
				tx_reg <= 1'b1;
				low_reg <= 1'b0;
				o_txd <= i_txb_data;
				sent_reg <= i_txb_data;
				chk_reg <= 1'b1;
				last_reg <= i_txb_last;
				o_take <= 1'b1;
				o_busy <= ~i_txb_data;
				bit_reg <= 3'h1;
				byte_reg <= 6'h00;
			end
			else
				o_txd <= 1'b1;
		end
	end
end

endmodule

// ---- tb/hab_top_properties.sv ----
// Concurrent checks on the ports of the HDLC auto-mode and bus access block
`timescale 1ns/10ps
`include "hab_consts.vh"
module hab_top_properties (
	// Clock and reset
	input wire i_mclk,
	input wire i_srst,
	// Register bus
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	input wire o_hreadyout,
	input wire o_hresp,
	// Frame path
	input wire i_rx_valid,
	input wire [1:0] i_rx_kind,
	input wire o_rxq_push,
	input wire o_rxq_drop,
	input wire o_rx_reset,
	input wire o_s_req,
	input wire o_s_cmd,
	// Line
	input wire o_txb_take,
	input wire o_txb_restart,
	input wire o_txb_done,
	input wire o_serial_data_out,
	input wire o_request_to_send_out,
	input wire o_bit_clk_en
);
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (i_srst);
	wire taken = i_hsel & i_htrans[1] & i_hready;
	sequence reset_cmd_write;
		taken && i_hwrite && i_haddr == {24'h00_0000, `HAB_A_CMD} ##1 i_hwdata[`HAB_M_RHR];
	endsequence
	sequence one_wait_state;
		!o_hreadyout ##1 o_hreadyout;
	endsequence
	chk_resp_okay: assert property (o_hresp == 1'b0)
		else $error("slave response not OKAY");
	chk_write_nowait: assert property (taken && i_hwrite |=> o_hreadyout)
		else $error("write inserted a wait state");
	chk_read_wait: assert property (taken && !i_hwrite |=> one_wait_state)
		else $error("read wait state wrong");
	chk_reset_issued: assert property (reset_cmd_write |-> ##[0:2] o_rx_reset)
		else $error("receiver reset not issued");
	chk_unnum_push: assert property (i_rx_valid && i_rx_kind == `HAB_K_U |-> ##[1:2] o_rxq_push)
		else $error("unnumbered frame not queued");
	chk_drop_answered: assert property (o_rxq_drop |-> ##[0:2] (o_s_req && !o_s_cmd))
		else $error("dropped frame not answered");
	chk_take_tick: assert property (o_txb_take |-> $past(o_bit_clk_en))
		else $error("bit taken off a bit tick");
	chk_rts_tick: assert property ($changed(o_request_to_send_out) |-> $past(o_bit_clk_en))
		else $error("send request moved off a bit tick");
	chk_done_idle: assert property (o_txb_done |-> o_serial_data_out)
		else $error("line not idle after frame");
	chk_abort_idle: assert property (o_txb_restart |-> ##[0:1] (o_serial_data_out && !o_request_to_send_out))
		else $error("collision did not abort");
endmodule
bind hab_top hab_top_properties hab_top_properties_i (.i_mclk, .i_srst, .i_hsel, .i_haddr,
	.i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .i_rx_valid, .i_rx_kind,
	.o_rxq_push, .o_rxq_drop, .o_rx_reset, .o_s_req, .o_s_cmd, .o_txb_take, .o_txb_restart,
	.o_txb_done, .o_serial_data_out, .o_request_to_send_out, .o_bit_clk_en);

// ---- tb/hab_remote.sv ----
// Remote station sharing the zero-dominant serial bus with the device
`timescale 1ns/10ps
module hab_remote (
	// Clock and control
	input wire i_mclk,
	input wire i_tick,
	input wire i_go,
	// Bus
	input wire i_dev_txd,
	output wire o_bus
);
	// Address 0x01 outranks the device's 0x03, so the device loses in the address field
	localparam logic [15:0] FRAME = 16'h7e01;
	logic [15:0] shift_reg = 16'h0000;
	logic [4:0] left_reg = 5'h00;
	logic txd_reg = 1'b1;
	always @(posedge i_mclk)
	begin
		if (i_go)
		begin
			shift_reg <= FRAME;
			left_reg <= 5'h10;
		end
		else if (i_tick && left_reg != 5'h00)
		begin
			txd_reg <= shift_reg[15];
			shift_reg <= {shift_reg[14:0], 1'b0};
			left_reg <= left_reg - 5'h01;
		end
		else if (i_tick)
			txd_reg <= 1'b1;
	end
	// Wired bus: any zero wins
	assign o_bus = i_dev_txd & txd_reg;
endmodule

// ---- tb/hdlc_auto_mode_bus_access_bench.sv ----
// Self-checking bench for the HDLC auto-mode and bus access block
`timescale 1ns/10ps
`include "hab_consts.vh"
module hdlc_auto_mode_bus_access_bench;
	localparam logic [15:0] FRAME = 16'h7e03;
	logic i_mclk = 1'b0;
	logic i_srst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic rxv = 1'b0;
	logic rxcmd = 1'b0;
	logic txdone = 1'b0;
	logic txv = 1'b0;
	logic go = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [1:0] kind = 2'h0;
	logic [1:0] styp = 2'h0;
	logic [2:0] ns = 3'h0;
	logic [2:0] nr = 3'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] rd;
	logic [1:0] lst;
	logic [2:0] lnr;
	logic [5:0] lns;
	wire [31:0] hrdata;
	wire [1:0] stype;
	wire [2:0] snr;
	wire [2:0] ins, inr;
	wire hrdy, push, drop, rxrst, sreq, spf, scmd, ireq, treq, take, restart, done;
	wire txd, rts, busy, bus, bclk;
	int idx = 0;
	int n_mismatch, checks_done, npush, ndrop, npoll, nrst, ni, nt, nres, ndone, nrts, nbusy;
	logic [31:0] rows [4][3] = '{'{32'h0000_0000, 32'h0000_003f, 32'h0000_003f},
		'{32'h0000_0010, 32'hffff_ffff, 32'h0fff_ffff},
		'{32'h0000_0014, 32'hffff_ffff, 32'h0000_07ff},
		'{32'h0000_0020, 32'hffff_ffff, 32'h0000_0000}};
	hab_top hab_top_i (.i_mclk(i_mclk), .i_srst(i_srst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
		.o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(), .i_rx_valid(rxv), .i_rx_kind(kind),
		.i_rx_stype(styp), .i_rx_ns(ns), .i_rx_nr(nr), .i_rx_pf(1'b0), .i_rx_cmd(rxcmd),
		.i_rx_info(1'b0), .o_rxq_push(push), .o_rxq_drop(drop), .o_rx_reset(rxrst),
		.o_s_req(sreq), .o_s_type(stype), .o_s_nr(snr), .o_s_pf(spf), .o_s_cmd(scmd),
		.o_i_req(ireq), .o_i_ns(ins), .o_i_nr(inr), .o_t_req(treq), .o_transmit_queue_blocked(),
		.i_tx_done(txdone), .i_txb_valid(txv && idx < 16), .i_txb_data(idx < 16 ? FRAME[15 - idx] : 1'b1),
		.i_txb_last(idx == 15), .o_txb_take(take), .o_txb_restart(restart), .o_txb_flush(),
		.o_txb_done(done), .i_rxd(1'b1), .i_ext_strobe(1'b0), .i_bus_feedback_in(bus),
		.o_serial_data_out(txd), .o_request_to_send_out(rts), .o_bus_busy(busy),
		.o_ref_clk_en(), .o_bit_clk_en(bclk));
	hab_remote hab_remote_i (.i_mclk(i_mclk), .i_tick(bclk), .i_go(go), .i_dev_txd(txd), .o_bus(bus));
	initial
		forever #2 i_mclk = ~i_mclk;
	// Pulses are counted mid-cycle, clear of the edge that launches them
	always @(negedge i_mclk)
	begin
		npush += (push === 1'b1);
		ndrop += (drop === 1'b1);
		npoll += ((sreq && spf && scmd) === 1'b1);
		nrst += (rxrst === 1'b1);
		ni += (ireq === 1'b1);
		nt += (treq === 1'b1);
		nres += (restart === 1'b1);
		ndone += (done === 1'b1);
		nrts += (rts === 1'b1);
		nbusy += (busy === 1'b1);
		if (sreq === 1'b1)
		begin
			lst = stype;
			lnr = snr;
		end
		if (ireq === 1'b1)
			lns = {inr, ins};
	end
	always @(posedge i_mclk)
		if (restart === 1'b1)
			idx <= 0;
		else if (take === 1'b1)
			idx <= idx + 1;
	// Wide enough for a counter, two fields and a register word side by side
	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge i_mclk);
		while (hrdy !== 1'b1)
			@(posedge i_mclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge i_mclk);
		while (hrdy !== 1'b1)
			@(posedge i_mclk);
		rd = hrdata;
	endtask
	task automatic rxf(input logic [1:0] k, input logic [1:0] s, input logic [2:0] n, input logic [2:0] r);
		@(posedge i_mclk);
		rxv <= 1'b1;
		rxcmd <= (k == `HAB_K_I);
		kind <= k;
		styp <= s;
		ns <= n;
		nr <= r;
		@(posedge i_mclk);
		rxv <= 1'b0;
		repeat (4) @(posedge i_mclk);
	endtask
	task automatic send_done;
		@(posedge i_mclk);
		txdone <= 1'b1;
		@(posedge i_mclk);
		txdone <= 1'b0;
		repeat (4) @(posedge i_mclk);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge i_mclk);
		n_mismatch++;
		$display("wrong value at %0t: watchdog expired", $time);
		complete_run;
	end
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge i_mclk);
		i_srst <= 1'b0;
		ahb(1'b0, `HAB_A_TIM, 32'h0);
		chk(rd, `HAB_TIM_RST);
		ahb(1'b0, `HAB_A_BAUD, 32'h0);
		chk(rd, `HAB_BAUD_RST);
		ahb(1'b0, `HAB_A_EVT, 32'h0);
		chk(rd, 32'h0000_0000);
		foreach (rows[r])
		begin
			ahb(1'b1, rows[r][0], rows[r][1]);
			ahb(1'b0, rows[r][0], 32'h0);
			chk(rd, rows[r][2]);
		end
		$display("done: registers");
		ahb(1'b1, `HAB_A_CTRL, 32'h0000_0001);
		rxf(`HAB_K_U, 2'h0, 3'h0, 3'h0);
		chk(npush, 1);
		rxf(`HAB_K_I, 2'h0, 3'h1, 3'h0);
		chk({ndrop, lst, lnr}, {32'd1, `HAB_S_RR, 3'h0});
		for (int i = 0; i < 9; i++)
			rxf(`HAB_K_I, 2'h0, i[2:0], 3'h0);
		chk({npush, lnr}, {32'd10, 3'h1});
		ahb(1'b1, `HAB_A_CTRL, 32'h0000_0005);
		rxf(`HAB_K_I, 2'h0, 3'h1, 3'h0);
		chk({ndrop, lst}, {32'd2, `HAB_S_RNR});
		ahb(1'b0, `HAB_A_EVT, 32'h0);
		chk(rd, 32'h0000_0000);
		ahb(1'b1, `HAB_A_CMD, 32'h0000_0001);
		ahb(1'b0, `HAB_A_STAT, 32'h0);
		chk({nrst, rd[5:0]}, {32'd1, 6'h00});
		$display("done: receive");
		ahb(1'b1, `HAB_A_TIM, 32'h0200_0014);
		ahb(1'b1, `HAB_A_CTRL, 32'h0000_0003);
		ahb(1'b1, `HAB_A_CMD, 32'h0000_0002);
		send_done;
		ahb(1'b0, `HAB_A_STAT, 32'h0);
		chk({ni, rd[12]}, {32'd1, 1'b1});
		rxf(`HAB_K_S, `HAB_S_RR, 3'h0, 3'h1);
		ahb(1'b0, `HAB_A_EVT, 32'h0);
		chk(rd, 32'h0000_0001);
		ahb(1'b1, `HAB_A_EVT, 32'h0000_001f);
		rxf(`HAB_K_S, `HAB_S_RNR, 3'h0, 3'h1);
		repeat (100) @(posedge i_mclk);
		ahb(1'b0, `HAB_A_EVT, 32'h0);
		chk({npoll, rd}, {32'd2, 32'h0000_000c});
		rxf(`HAB_K_S, `HAB_S_RR, 3'h0, 3'h1);
		ahb(1'b1, `HAB_A_EVT, 32'h0000_001f);
		ahb(1'b1, `HAB_A_CMD, 32'h0000_0002);
		send_done;
		repeat (100) @(posedge i_mclk);
		ahb(1'b0, `HAB_A_EVT, 32'h0);
		chk({npoll, lns, rd}, {32'd4, 6'h01, 32'h0000_0004});
		ahb(1'b1, `HAB_A_EVT, 32'h0000_001f);
		$display("done: link procedure");
		ahb(1'b1, `HAB_A_CTRL, 32'h0000_0000);
		ahb(1'b1, `HAB_A_CMD, 32'h0000_0004);
		send_done;
		ahb(1'b0, `HAB_A_EVT, 32'h0);
		chk({nt, rd}, {32'd1, 32'h0000_0001});
		ahb(1'b0, `HAB_A_STAT, 32'h0);
		chk(rd[12], 1'b0);
		$display("done: transparent");
		// Ratio 2 gives the bit source one cycle to follow each take
		ahb(1'b1, `HAB_A_BAUD, 32'h0000_0001);
		ahb(1'b1, `HAB_A_CTRL, 32'h0000_0008);
		// Let the idle count fill so both stations start into a collision
		repeat (20) @(posedge i_mclk);
		txv <= 1'b1;
		go <= 1'b1;
		@(posedge i_mclk);
		go <= 1'b0;
		for (int j = 0; j < 400 && ndone == 0; j++)
			@(posedge i_mclk);
		txv <= 1'b0;
		chk({nres != 0, nrts != 0, nbusy != 0}, 3'h7);
		chk({ndone, txd}, {32'd1, 1'b1});
		$display("done: bus access");
		i_srst <= 1'b1;
		repeat (6) @(posedge i_mclk);
		i_srst <= 1'b0;
		ahb(1'b0, `HAB_A_TIM, 32'h0);
		chk(rd, `HAB_TIM_RST);
		$display("done: second reset");
		complete_run;
	end
endmodule
